// [main_memory_addr_mapper.sv]
// The implementer's own choice: the Wishbone slave port.
module main_memory_addr_mapper
  import main_memory_addr_mapper_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [23:1] memAddr,
  input wire logic [1:0] memByteEn,
  output logic memAck,
  output logic [23:1] systemAddressBus,
  output logic [3:0] colStrobeSelN,
  output logic [1:0] rowStrobeN,
  output logic memoryWriteStrobeN
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] waitExt_r, waitExt_nxt, version_r, version_nxt, memCfg_r, memCfg_nxt;
  logic [7:0] miscType_r, miscType_nxt, symSize_r, symSize_nxt, altSize_r, altSize_nxt;
  logic wbAck_r, wbAck_nxt;
  logic [7:0] wbDat_r, wbDat_nxt;
  state_t state_r, state_nxt;
  logic [23:1] addr_r, addr_nxt;
  logic we_r, we_nxt;
  logic [1:0] be_r, be_nxt;
  logic bank_r, bank_nxt;
  logic [1:0] waitCnt_r, waitCnt_nxt;
  logic memAck_r, memAck_nxt;
  pins_t pins_r, pins_nxt;
  cfg_t cfg;
  logic sramMode, enhActive, cfgValid;
  logic [1:0] rdWait, wrWait;
  logic [7:0] regIdx, status;
  mux_t rowNow, colLat;

  // ****************************************
  // Address translation
  // ****************************************
  function automatic mux_t mapAddr(input cfg_t c, input logic enh, input logic [23:1] a);
    mux_t m;
    m = '0;
    m.row[9:0] = a[19:10];
    m.col[8:0] = a[9:1];
    case (c)
      CFG_2X1M: begin
        m.bank = a[20];
        if (enh) begin
          m.row[0] = a[20];
          m.bank = a[10];
        end
      end
      CFG_2M: begin
        m.row[0] = a[20];
        m.col[9] = a[10];
      end
      CFG_2X2M: begin
        m.row[0] = a[20];
        m.col[9] = a[10];
        m.bank = a[21];
        if (enh) begin
          m.row[1] = a[21];
          m.bank = a[11];
        end
      end
      CFG_8M, CFG_2X8M: begin
        m.row[0] = a[20];
        m.row[1] = a[21];
        m.row[10] = a[22];
        m.col[9] = a[10];
        m.col[10] = a[11];
        if (c == CFG_2X8M) begin
          m.bank = a[23];
          if (enh) begin
            m.row[2] = a[23];
            m.bank = a[12];
          end
        end
      end
      CFG_512K: m.row[9] = 1'b0;
      CFG_2X512K: begin
        m.row[9] = 1'b0;
        m.bank = a[19];
        if (enh) begin
          m.row[0] = a[19];
          m.bank = a[10];
        end
      end
      CFG_2M_ASYM: begin
        m.row[11] = a[20];
        m.row[10] = a[9];
        m.col[8] = 1'b0;
      end
      CFG_2X2M_ASYM: begin
        m.row[11] = a[20];
        m.row[10] = a[21];
        m.col[8] = 1'b0;
        m.bank = a[9];
      end
      default: m.bank = 1'b0;
    endcase
    return m;
  endfunction

  // Places the multiplexed address on the shared upper system address pins.
  function automatic logic [23:1] placeOnSa(input logic [11:0] ma, input logic [23:1] a);
    logic [23:1] s;
    s = a;
    s[23:14] = ma[9:0];
    s[13] = ma[10];
    s[12] = ma[11];
    return s;
  endfunction

  // ****************************************
  // Configuration decode
  // ****************************************
  always_comb begin
    cfg = CFG_NONE;
    if (!altSize_r[BIT_ALT_SIZE]) begin
      case (memCfg_r[MS_LSB+2:MS_LSB])
        3'h1: cfg = CFG_1M;
        3'h2: cfg = CFG_2X1M;
        3'h3: cfg = CFG_2M;
        3'h4: cfg = CFG_2X2M;
        3'h5: cfg = CFG_8M;
        3'h6: cfg = CFG_2X8M;
        default: cfg = CFG_NONE;
      endcase
    end else begin
      case (symSize_r[SYM_LSB+1:SYM_LSB])
        2'h0: cfg = CFG_512K;
        2'h1: cfg = CFG_2X512K;
        2'h2: cfg = CFG_2M_ASYM;
        default: cfg = CFG_2X2M_ASYM;
      endcase
    end
    sramMode = miscType_r[BIT_SRAM_SEL];
    // enhanced mode needs the DRAM option bit.
    // enhanced two 1M banks also needs the version bit.
    enhActive = !sramMode && memCfg_r[BIT_ENH] && memCfg_r[BIT_DRAM_OPT]
                && (cfg != CFG_2X1M || version_r[BIT_ENH_2M]);
    // two-bank asymmetric DRAM only in enhanced mode.
    cfgValid = (cfg != CFG_NONE) && (sramMode || enhActive || cfg != CFG_2X2M_ASYM);
    rdWait = WS_TWO;
    wrWait = WS_TWO;
    if (memCfg_r[1:0] == 2'h0) begin
      rdWait = WS_ZERO;
      wrWait = WS_ONE;
    end else if (memCfg_r[1:0] == 2'h1 && !waitExt_r[BIT_WAIT_EXT]) begin
      rdWait = WS_ONE;
      wrWait = WS_ONE;
    end
    rowNow = mapAddr(cfg, enhActive, memAddr);
    colLat = mapAddr(cfg, enhActive, addr_r);
    status = {cfg, state_r != ST_IDLE, cfgValid, enhActive, sramMode};
  end

  // ****************************************
  // Register bus
  // ****************************************
  always_comb begin
    regIdx = wb_adr_i[9:2];
    waitExt_nxt = waitExt_r;
    version_nxt = version_r;
    memCfg_nxt = memCfg_r;
    miscType_nxt = miscType_r;
    symSize_nxt = symSize_r;
    altSize_nxt = altSize_r;
    wbAck_nxt = wb_cyc_i && wb_stb_i && !wbAck_r;
    wbDat_nxt = wbDat_r;
    if (wbAck_nxt) begin
      if (regIdx == IDX_WAIT_EXT) begin
        wbDat_nxt = waitExt_r;
      end else if (regIdx == IDX_VERSION) begin
        wbDat_nxt = version_r;
      end else if (regIdx == IDX_MEM_CFG) begin
        wbDat_nxt = memCfg_r;
      end else if (regIdx == IDX_MISC_TYPE) begin
        wbDat_nxt = miscType_r;
      end else if (regIdx == IDX_SYM_SIZE) begin
        wbDat_nxt = symSize_r;
      end else if (regIdx == IDX_ALT_SIZE) begin
        wbDat_nxt = altSize_r;
      end else if (regIdx == IDX_STATUS) begin
        wbDat_nxt = status;
      end else begin
        wbDat_nxt = 8'h00;
      end
    end
    // Writes land at the edge where the master samples ack high.
    if (wbAck_r && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
      if (regIdx == IDX_WAIT_EXT) begin
        waitExt_nxt = wb_dat_i[7:0];
      end else if (regIdx == IDX_VERSION) begin
        version_nxt = wb_dat_i[7:0];
      end else if (regIdx == IDX_MEM_CFG) begin
        memCfg_nxt = wb_dat_i[7:0];
      end else if (regIdx == IDX_MISC_TYPE) begin
        miscType_nxt = wb_dat_i[7:0];
      end else if (regIdx == IDX_SYM_SIZE) begin
        symSize_nxt = wb_dat_i[7:0];
      end else if (regIdx == IDX_ALT_SIZE) begin
        altSize_nxt = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      waitExt_r <= RST_REG;
      version_r <= RST_REG;
      memCfg_r <= RST_REG;
      miscType_r <= RST_REG;
      symSize_r <= RST_REG;
      altSize_r <= RST_REG;
      wbAck_r <= 1'b0;
      wbDat_r <= RST_REG;
    end else begin
      waitExt_r <= waitExt_nxt;
      version_r <= version_nxt;
      memCfg_r <= memCfg_nxt;
      miscType_r <= miscType_nxt;
      symSize_r <= symSize_nxt;
      altSize_r <= altSize_nxt;
      wbAck_r <= wbAck_nxt;
      wbDat_r <= wbDat_nxt;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  // every access step advances on the system clock.
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    we_nxt = we_r;
    be_nxt = be_r;
    bank_nxt = bank_r;
    waitCnt_nxt = waitCnt_r;
    memAck_nxt = 1'b0;
    pins_nxt = pins_r;
    case (state_r)
      ST_IDLE: begin
        if (memReq) begin
          addr_nxt = memAddr;
          we_nxt = memWe;
          be_nxt = memByteEn;
          bank_nxt = rowNow.bank;
          if (!cfgValid) begin
            state_nxt = ST_DONE;
            memAck_nxt = 1'b1;
          end else if (sramMode) begin
            // word address straight onto the system address bus.
            pins_nxt.sa = memAddr;
            // byte selects by bank and lane.
            pins_nxt.strobeSelN[{rowNow.bank, 1'b0}] = !memByteEn[0];
            pins_nxt.strobeSelN[{rowNow.bank, 1'b1}] = !memByteEn[1];
            pins_nxt.writeN = !memWe;
            waitCnt_nxt = memWe ? wrWait : rdWait;
            state_nxt = ST_SRAM;
          end else begin
            // row address on the shared pins.
            pins_nxt.sa = placeOnSa(rowNow.row, memAddr);
            pins_nxt.rowStrobeN[rowNow.bank] = 1'b0;
            state_nxt = ST_ROW;
          end
        end
      end
      ST_ROW: begin
        // column phase follows the row phase.
        pins_nxt.sa = placeOnSa(colLat.col, addr_r);
        pins_nxt.strobeSelN[{bank_r, 1'b0}] = !be_r[0];
        pins_nxt.strobeSelN[{bank_r, 1'b1}] = !be_r[1];
        pins_nxt.writeN = !we_r;
        state_nxt = ST_COL;
      end
      ST_COL: begin
        pins_nxt.strobeSelN = 4'hf;
        pins_nxt.rowStrobeN = 2'h3;
        pins_nxt.writeN = 1'b1;
        memAck_nxt = 1'b1;
        state_nxt = ST_DONE;
      end
      ST_SRAM: begin
        // hold the access for the selected wait states.
        if (waitCnt_r == 2'h0) begin
          pins_nxt.strobeSelN = 4'hf;
          pins_nxt.writeN = 1'b1;
          memAck_nxt = 1'b1;
          state_nxt = ST_DONE;
        end else begin
          waitCnt_nxt = waitCnt_r - 2'h1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      we_r <= 1'b0;
      be_r <= 2'h0;
      bank_r <= 1'b0;
      waitCnt_r <= 2'h0;
      memAck_r <= 1'b0;
      pins_r <= '{sa: '0, strobeSelN: 4'hf, rowStrobeN: 2'h3, writeN: 1'b1};
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      we_r <= we_nxt;
      be_r <= be_nxt;
      bank_r <= bank_nxt;
      waitCnt_r <= waitCnt_nxt;
      memAck_r <= memAck_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign wb_ack_o = wbAck_r;
  assign wb_dat_o = {24'h000000, wbDat_r};
  assign memAck = memAck_r;
  assign systemAddressBus = pins_r.sa;
  assign colStrobeSelN = pins_r.strobeSelN;
  assign rowStrobeN = pins_r.rowStrobeN;
  assign memoryWriteStrobeN = pins_r.writeN;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_sram_no_ras: assert property (state_r == ST_SRAM |-> rowStrobeN == 2'h3)
    else $error("Row strobe active during SRAM access.");
  a_sram_bank_lane: assert property ((state_r == ST_SRAM && !bank_r) |->
    colStrobeSelN[3:2] == 2'h3 && colStrobeSelN[0] == !be_r[0])
    else $error("SRAM select on wrong bank or lane.");
  a_sram_word_addr: assert property (state_r == ST_SRAM |-> systemAddressBus == addr_r)
    else $error("SRAM address differs from request.");
  a_ms_decode: assert property ((!altSize_r[7] && memCfg_r[4:2] == 3'h6) |-> cfg == CFG_2X8M)
    else $error("Size field decoded wrongly.");
  a_alt_decode: assert property ((altSize_r[7] && symSize_r[7:6] == 2'h2) |-> cfg == CFG_2M_ASYM)
    else $error("Alternate size decoded wrongly.");
  a_enh_needs_opt: assert property (!memCfg_r[1] |-> !enhActive)
    else $error("Enhanced mode without DRAM option bit.");
  a_wait_zero: assert property ((state_r == ST_IDLE && memReq && sramMode && cfgValid
    && memCfg_r[1:0] == 2'h0 && !memWe) |=> state_r == ST_SRAM ##1 memAck)
    else $error("Zero-wait SRAM read took the wrong time.");
  a_wait_ext: assert property ((state_r == ST_IDLE && memReq && sramMode && cfgValid
    && memCfg_r[1:0] == 2'h1 && waitExt_r[4]) |=> (state_r == ST_SRAM) [*3] ##1 memAck)
    else $error("Extended SRAM wait wrong.");
  a_dram_seq: assert property ((state_r == ST_IDLE && memReq && !sramMode && cfgValid)
    |=> state_r == ST_ROW ##1 state_r == ST_COL ##1 memAck)
    else $error("DRAM row/column sequence broken.");
  a_row_col_1m: assert property ((state_r == ST_ROW && cfg == CFG_1M) |->
    systemAddressBus[23:14] == addr_r[19:10] ##1 systemAddressBus[22:14] == addr_r[9:1])
    else $error("1M row or column mapping wrong.");
  a_enh_row_high: assert property ((state_r == ST_ROW && cfg == CFG_2X2M && enhActive) |->
    systemAddressBus[14] == addr_r[20] && systemAddressBus[15] == addr_r[21])
    else $error("Enhanced row bits not moved.");
  a_asym_pins: assert property ((state_r == ST_ROW && cfg == CFG_2M_ASYM) |->
    systemAddressBus[12] == addr_r[20] && systemAddressBus[13] == addr_r[9])
    else $error("Asymmetric row on shared pins wrong.");
  a_pin_share: assert property ((state_r == ST_COL && cfg == CFG_8M) |->
    systemAddressBus[13] == addr_r[11] && systemAddressBus[12] == 1'b0)
    else $error("Shared pin order wrong.");

  c_sram_write: cover property (state_r == ST_SRAM && !memoryWriteStrobeN ##1 memAck);
  c_dram_enh: cover property (state_r == ST_ROW && enhActive);
  c_reg_write: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);

endmodule

// [main_memory_addr_mapper_pkg.sv]
//
// Overview of operation
// - Memory-type select bit switches to SRAM; column strobes become byte selects.
// - Select 0/1 are bank 0 low/high bytes, select 2/3 bank 1.
// - SRAM spans 16 Mbyte, two 16-bit banks, word address on bits 23..1.
// - Three-bit size field picks 1M, 2x1M, 2M, 2x2M, 8M or 2x8M.
// - Enhanced-page bit enables enhanced mode; DRAM also needs option bit 1.
// - With SRAM, configuration bits 1..0 select wait states.
// - Wait states: 00 gives 0/1, 01 gives 1/1, extended 01 gives 2/2.
// - Asymmetric row/column addressing serves 512K x8 and 1M x16 parts.
// - 1M-per-bank page mode: row A19..A10, column A9..A1 on upper pins.
// - All memory transfers run synchronously with the system clock.
// - Twelve multiplexed address outputs share upper system address pins.
//
package main_memory_addr_mapper_pkg;

  // ****************************************
  // Register indices and bit positions
  // ****************************************
  localparam logic [7:0] IDX_WAIT_EXT = 8'h63;
  localparam logic [7:0] IDX_VERSION = 8'h64;
  localparam logic [7:0] IDX_MEM_CFG = 8'h66;
  localparam logic [7:0] IDX_MISC_TYPE = 8'h70;
  localparam logic [7:0] IDX_SYM_SIZE = 8'hb1;
  localparam logic [7:0] IDX_ALT_SIZE = 8'hb4;
  localparam logic [7:0] IDX_STATUS = 8'hc0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int BIT_WAIT_EXT = 4;
  localparam int BIT_ENH_2M = 4;
  localparam int BIT_ENH = 0;
  localparam int BIT_DRAM_OPT = 1;
  localparam int BIT_SRAM_SEL = 0;
  localparam int BIT_ALT_SIZE = 7;
  localparam int MS_LSB = 2;
  localparam int SYM_LSB = 6;

  // ****************************************
  // SRAM wait-state counts
  // ****************************************
  localparam logic [1:0] WS_ZERO = 2'h0;
  localparam logic [1:0] WS_ONE = 2'h1;
  localparam logic [1:0] WS_TWO = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    CFG_NONE, CFG_1M, CFG_2X1M, CFG_2M, CFG_2X2M, CFG_8M, CFG_2X8M,
    CFG_512K, CFG_2X512K, CFG_2M_ASYM, CFG_2X2M_ASYM
  } cfg_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_SRAM, ST_DONE} state_t;

  typedef struct packed {
    logic [11:0] row;
    logic [11:0] col;
    logic bank;
  } mux_t;

  typedef struct packed {
    logic [23:1] sa;
    logic [3:0] strobeSelN;
    logic [1:0] rowStrobeN;
    logic writeN;
  } pins_t;

endpackage

// [main_memory_addr_mapper_tb.sv]
module main_memory_addr_mapper_tb import main_memory_addr_mapper_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic memReq, memWe, memAck, memoryWriteStrobeN, writeSeen;
  logic [23:1] memAddr, systemAddressBus, sramAddr;
  logic [1:0] memByteEn, rowStrobeN, rowBankN;
  logic [3:0] colStrobeSelN, laneSelN, selCycles;
  logic [11:0] rowAddr, colAddr;
  int failCount = 0;
  int testsRun = 0;
  int nRef;
  localparam logic [23:1] ADR_HIGH = 23'h7da7c3;
  localparam logic [23:1] ADR_LOW = 23'h02583c;
  logic [7:0] regIdx [6] = '{IDX_WAIT_EXT, IDX_VERSION, IDX_MEM_CFG, IDX_MISC_TYPE,
    IDX_SYM_SIZE, IDX_ALT_SIZE};

  main_memory_addr_mapper i_main_memory_addr_mapper (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .memReq, .memWe, .memAddr,
    .memByteEn, .memAck, .systemAddressBus, .colStrobeSelN, .rowStrobeN, .memoryWriteStrobeN);

  mem_partner_model i_mem_partner_model (.sys_clk, .rst_b, .systemAddressBus, .colStrobeSelN,
    .rowStrobeN, .memoryWriteStrobeN, .rowAddr, .colAddr, .rowBankN, .laneSelN, .writeSeen,
    .sramAddr, .selCycles);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Reporting
  // ****************************************
  task results;
    $display("checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task timeout(input string what);
    failCount++;
    $display("unexpected %s: no answer", what);
    results();
  endtask

  // ****************************************
  // Bus access
  // ****************************************
  task wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rdat);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) timeout("register ack");
    rdat = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] junk;
    wb(1'b1, idx, d, junk);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, v);
    check(what, {24'h000000, v}, {24'h000000, exp});
  endtask

  task cfg(input logic [7:0] misc, alt, sym, ver, wext, mem1);
    wr(IDX_MISC_TYPE, misc);
    wr(IDX_ALT_SIZE, alt);
    wr(IDX_SYM_SIZE, sym);
    wr(IDX_VERSION, ver);
    wr(IDX_WAIT_EXT, wext);
    wr(IDX_MEM_CFG, mem1);
  endtask

  // ****************************************
  // Memory access
  // ****************************************
  task mem(input logic we, input logic [23:1] a, input logic [1:0] be, output int n);
    @(posedge sys_clk);
    memReq <= 1'b1;
    memWe <= we;
    memAddr <= a;
    memByteEn <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (memAck !== 1'b1 && n < 20);
    if (n >= 20) timeout("memory ack");
    memReq <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [3:0] laneExp(input logic bank, input logic [1:0] be);
    return bank ? {~be, 2'h3} : {2'h3, ~be};
  endfunction

  task scen(input int k, input logic [23:1] a, input logic [1:0] be);
    logic [11:0] r;
    logic [11:0] c;
    logic b;
    int n;
    case (k)
      1, 2: begin r = {2'h0, a[19:10]}; c = {3'h0, a[9:1]}; b = k == 2 && a[20]; end
      3, 4: begin r = {2'h0, a[19:11], a[20]}; c = {2'h0, a[10:1]}; b = k == 4 && a[21]; end
      5, 6: begin r = {1'b0, a[22], a[19:12], a[21:20]}; c = {1'b0, a[11:1]}; b = k == 6 && a[23]; end
      7, 8: begin r = {3'h0, a[18:10]}; c = {3'h0, a[9:1]}; b = k == 8 && a[19]; end
      9: begin r = {a[20], a[9], a[19:10]}; c = {4'h0, a[8:1]}; b = 1'b0; end
      10: begin r = {a[20], a[21], a[19:10]}; c = {4'h0, a[8:1]}; b = a[9]; end
      12: begin r = {2'h0, a[19:12], a[21:20]}; c = {2'h0, a[10:1]}; b = a[11]; end
      default: begin r = {2'h0, a[19:11], a[20]}; c = {3'h0, a[9:1]}; b = a[10]; end
    endcase
    if (k < 7) cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'(k << 2));
    else if (k < 11) cfg(8'h00, 8'h80, 8'((k - 7) << 6), 8'h00, 8'h00, k == 10 ? 8'h03 : 8'h00);
    else cfg(8'h00, 8'h00, 8'h00, k == 11 ? 8'h10 : 8'h00, 8'h00, k == 11 ? 8'h0b : 8'h13);
    if (k > 10) rd(IDX_STATUS, k == 11 ? 8'h26 : 8'h46, "enhanced status");
    mem(1'b1, a, be, n);
    check("dram cycles", n, 4);
    check("row address", rowAddr, r);
    check("column address", colAddr, c);
    check("row bank", rowBankN, b ? 2'h1 : 2'h2);
    check("column lanes", laneSelN, laneExp(b, be));
    check("column cycles", selCycles, 1);
    check("write strobe", writeSeen, 1'b1);
  endtask

  task sram(input logic we, input logic [23:1] a, input logic [1:0] be, input int ws);
    int n;
    mem(we, a, be, n);
    check("sram cycles", n, 3 + ws);
    check("select cycles", selCycles, 1 + ws);
    check("sram address", sramAddr, a);
    check("byte selects", laneSelN, laneExp(a[20], be));
    check("sram write strobe", writeSeen, we);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    memReq = 1'b0;
    memWe = 1'b0;
    memAddr = 23'h000000;
    memByteEn = 2'h0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) rd(regIdx[i], RST_REG, "reset value");
    for (int i = 0; i < 6; i++) begin
      wr(regIdx[i], 8'h5a ^ 8'(i));
      rd(regIdx[i], 8'h5a ^ 8'(i), "readback");
    end
    wr(8'h65, 8'hff);
    rd(8'h65, 8'h00, "unmapped index");
    for (int k = 1; k < 13; k++) begin
      scen(k, ADR_HIGH, 2'h3);
      scen(k, ADR_LOW, 2'h1);
    end
    for (int k = 0; k < 3; k++) begin
      cfg(8'h01, 8'h00, 8'h00, 8'h00, k == 2 ? 8'h10 : 8'h00, k == 0 ? 8'h08 : 8'h09);
      rd(IDX_STATUS, 8'h25, "sram status");
      sram(1'b0, ADR_LOW, 2'h1, k);
      sram(1'b1, ADR_HIGH, 2'h2, k == 0 ? 1 : k);
    end
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rd(IDX_STATUS, 8'h00, "invalid status");
    mem(1'b0, ADR_LOW, 2'h3, nRef);
    check("refused cycles", nRef, 2);
    check("refused address", sramAddr, ADR_HIGH);
    results();
  end
endmodule

// [mem_partner_model.sv]
module mem_partner_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [23:1] systemAddressBus,
  input wire logic [3:0] colStrobeSelN,
  input wire logic [1:0] rowStrobeN,
  input wire logic memoryWriteStrobeN,
  output logic [11:0] rowAddr,
  output logic [11:0] colAddr,
  output logic [1:0] rowBankN,
  output logic [3:0] laneSelN,
  output logic writeSeen,
  output logic [23:1] sramAddr,
  output logic [3:0] selCycles
);
  logic [11:0] muxPins;
  logic rowOn;
  logic selOn;

  // ****************************************
  // Pin decode
  // ****************************************
  // multiplexed address pins.
  assign muxPins = {systemAddressBus[12], systemAddressBus[13], systemAddressBus[23:14]};

  // ****************************************
  // Strobe capture
  // ****************************************
  // sampled on clock.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rowAddr <= 12'h000;
      colAddr <= 12'h000;
      rowBankN <= 2'h3;
      laneSelN <= 4'hf;
      writeSeen <= 1'b0;
      sramAddr <= 23'h000000;
      selCycles <= 4'h0;
      rowOn <= 1'b0;
      selOn <= 1'b0;
    end else begin
      if (rowStrobeN != 2'h3 && !rowOn) begin
        rowAddr <= muxPins;
        rowBankN <= rowStrobeN;
      end
      if (colStrobeSelN != 4'hf) begin
        if (!selOn) begin
          colAddr <= muxPins;
          laneSelN <= colStrobeSelN;
          sramAddr <= systemAddressBus;
          writeSeen <= !memoryWriteStrobeN;
          selCycles <= 4'h1;
        end else begin
          selCycles <= selCycles + 4'h1;
        end
      end
      rowOn <= rowStrobeN != 2'h3;
      selOn <= colStrobeSelN != 4'hf;
    end
  end
endmodule
